// ### design/adc_output_format_control.sv
// Output-format register bank with control-bit muxing and overrange flags
//
// Chosen here: the Wishbone slave port.
module adc_output_format_control
  import ofc_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                core_clk,
  input  wire logic                srst,
  input  wire logic                clk_en,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [13:0]         wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // Converter samples and flags, same clock
  input  wire logic [SAMPLE_W-1:0] samp_a,
  input  wire logic [SAMPLE_W-1:0] samp_b,
  input  wire sample_flags_t       flags_a,
  input  wire sample_flags_t       flags_b,
  input  wire logic [NUM_VC-1:0]   vc_overrange,
  // Formatted output
  output out_word_t                out_a_q,
  output out_word_t                out_b_q,
  output logic                     lane_rate_low_q,
  output logic                     irq_q
);

  // ==========================================================
  // Register storage
  logic [7:0]        sel_a_q, sel_b_q, format_q, or_clear_q, ch_order_q, lane_q;
  logic [7:0]        irq_stat_q, irq_mask_q;
  logic [1:0]        ctrl_cnt_q;
  logic [NUM_VC-1:0] or_flags_q;

  logic        req;
  logic        wr_stb;
  logic [11:0] idx;
  logic [7:0]  wdat;

  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_stb = req && wb_we_i && wb_sel_i[0] && clk_en;
  assign idx    = wb_adr_i[13:2];
  assign wdat   = wb_dat_i[7:0];

  function automatic logic wr_hit(input logic [11:0] a);
    return wr_stb && (idx == a);
  endfunction

  function automatic logic [SAMPLE_W-1:0] fmt_sample(
    input logic [SAMPLE_W-1:0] s, input logic [7:0] f);
    logic [SAMPLE_W-1:0] r;
    r = s;
    if (f[1:0] == FMT_OFFSET_BIN) begin
      r[SAMPLE_W-1] = ~r[SAMPLE_W-1];
    end
    if (f[FMT_INVERT]) begin
      r = ~r;
    end
    return r;
  endfunction

  // ==========================================================
  // Wishbone answer, one cycle after the request
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wb_ack_o <= 1'b0;
    end else if (clk_en) begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en && req) begin
      unique case (idx)
        IDX_SEL_A:     wb_dat_o <= {24'h000000, sel_a_q};
        IDX_SEL_B:     wb_dat_o <= {24'h000000, sel_b_q};
        IDX_FORMAT:    wb_dat_o <= {24'h000000, format_q};
        IDX_OR_CLEAR:  wb_dat_o <= {24'h000000, or_clear_q};
        IDX_OR_FLAGS:  wb_dat_o <= {24'h000000, or_flags_q};
        IDX_CH_ORDER:  wb_dat_o <= {24'h000000, ch_order_q};
        IDX_LANE_RATE: wb_dat_o <= {24'h000000, lane_q};
        IDX_IRQ_STAT:  wb_dat_o <= {24'h000000, irq_stat_q};
        IDX_IRQ_MASK:  wb_dat_o <= {24'h000000, irq_mask_q};
        IDX_CTRL_CNT:  wb_dat_o <= {30'h00000000, ctrl_cnt_q};
        default:       wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sel_a_q    <= RST_SEL_A;
      sel_b_q    <= RST_SEL_B;
      format_q   <= RST_FORMAT;
      or_clear_q <= RST_OR_CLEAR;
      ch_order_q <= RST_CH_ORDER;
      lane_q     <= RST_LANE_RATE;
      irq_mask_q <= RST_IRQ_MASK;
      ctrl_cnt_q <= RST_CTRL_CNT;
    end else begin
      if (wr_hit(IDX_SEL_A))     sel_a_q    <= wdat & MASK_SEL_A;
      if (wr_hit(IDX_SEL_B))     sel_b_q    <= wdat & MASK_SEL_B;
      if (wr_hit(IDX_FORMAT))    format_q   <= wdat & MASK_FORMAT;
      if (wr_hit(IDX_OR_CLEAR))  or_clear_q <= wdat;
      if (wr_hit(IDX_CH_ORDER))  ch_order_q <= wdat & MASK_CH_ORDER;
      if (wr_hit(IDX_LANE_RATE)) lane_q     <= wdat & MASK_LANE_RATE;
      if (wr_hit(IDX_IRQ_MASK))  irq_mask_q <= wdat;
      if (wr_hit(IDX_CTRL_CNT))  ctrl_cnt_q <= wdat[1:0];
    end
  end

  // ==========================================================
  // Overrange flags
  logic [NUM_VC-1:0] or_clr_pulse;
  assign or_clr_pulse = wr_hit(IDX_OR_CLEAR) ? wdat : 8'h00;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      or_flags_q <= 8'h00;
    end else if (clk_en) begin
      // Sticky until clear, held at zero while clear bit is 1
      or_flags_q <= ((or_flags_q & ~or_clr_pulse) | vc_overrange) & ~or_clear_q;
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear, set wins
  logic [7:0] new_or;
  assign new_or = vc_overrange & ~or_flags_q & ~or_clear_q;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_stat_q <= 8'h00;
    end else if (clk_en) begin
      irq_stat_q <= (irq_stat_q & ~(wr_hit(IDX_IRQ_STAT) ? wdat : 8'h00)) | new_or;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ==========================================================
  // Control-bit muxes
  logic [2:0] ctl_a, ctl_b;
  logic [2:0] present;
  sample_flags_t fa, fb;

  assign present = {ctrl_cnt_q == 2'h3, ctrl_cnt_q >= 2'h2, ctrl_cnt_q != 2'h0};
  assign fa = ch_order_q[0] ? flags_b : flags_a;
  assign fb = ch_order_q[0] ? flags_a : flags_b;

  for (genvar i = 0; i < 3; i++) begin : g_mux
    logic [2:0] code;
    if (i == 0) begin : g0
      assign code = sel_a_q[SEL_BIT0_LSB +: 3];
    end else if (i == 1) begin : g1
      assign code = sel_a_q[SEL_BIT1_LSB +: 3];
    end else begin : g2
      assign code = sel_b_q[SEL_BIT2_LSB +: 3];
    end
    ctrl_bit_mux u_mux_a (
      .code    (code),
      .present (present[i]),
      .flags   (fa),
      .bit_out (ctl_a[i])
    );
    ctrl_bit_mux u_mux_b (
      .code    (code),
      .present (present[i]),
      .flags   (fb),
      .bit_out (ctl_b[i])
    );
  end

  // ==========================================================
  // Output stage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      out_a_q <= '0;
      out_b_q <= '0;
    end else if (clk_en) begin
      out_a_q <= '{sample: fmt_sample(ch_order_q[0] ? samp_b : samp_a, format_q), ctrl: ctl_a};
      out_b_q <= '{sample: fmt_sample(ch_order_q[0] ? samp_a : samp_b, format_q), ctrl: ctl_b};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lane_rate_low_q <= RST_LANE_RATE[4];
    end else if (clk_en) begin
      lane_rate_low_q <= lane_q[4];
    end
  end

  // ==========================================================
  // Checks
  // sticky flags
  chk_or_sticky: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && !$past(srst) && $past(clk_en) && $past(or_flags_q[0]) && !$past(or_clear_q[0])
    && !$past(or_clr_pulse[0]) |-> or_flags_q[0])
    else $error("overrange flag dropped without clear");
  chk_or_cleared: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && or_clear_q[0] |=> !clk_en || or_flags_q[0] == 1'b0 || !or_clear_q[0])
    else $error("flag set while cleared");
  chk_or_set: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && vc_overrange[2] && !or_clear_q[2] |=> or_flags_q[2])
    else $error("overrange not recorded");
  chk_swap_order: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && ch_order_q[0] && format_q == 8'h01 |=> out_a_q.sample == $past(samp_b))
    else $error("channel swap wrong");
  chk_fmt_offset: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && format_q == 8'h00 && !ch_order_q[0]
    |=> out_a_q.sample == {~$past(samp_a[SAMPLE_W-1]), $past(samp_a[SAMPLE_W-2:0])})
    else $error("offset binary wrong");
  chk_fmt_invert: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && format_q == 8'h05 && !ch_order_q[0] |=> out_a_q.sample == ~$past(samp_a))
    else $error("invert wrong");
  chk_tie_low: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && sel_b_q[2:0] == 3'h0 |=> out_a_q.ctrl[2] == 1'b0)
    else $error("tied bit not low");
  chk_absent_low: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && ctrl_cnt_q == 2'h0 |=> out_b_q.ctrl == 3'h0)
    else $error("absent control bit driven");
  chk_ack_pulse: assert property (@(posedge core_clk) disable iff (srst)
    wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && req |=> wb_ack_o)
    else $error("request not acknowledged");
  chk_read_flags: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && req && !wb_we_i && idx == IDX_OR_FLAGS
    |=> wb_dat_o == {24'h000000, $past(or_flags_q)})
    else $error("status read wrong");
  chk_or_clear_pulse: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && or_clr_pulse[0] && !vc_overrange[0] |=> !or_flags_q[0])
    else $error("flag kept after clear write");
  chk_ctrl_source: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && ctrl_cnt_q == 2'h3 && sel_b_q[2:0] == 3'h3 && !ch_order_q[0]
    |=> out_a_q.ctrl[2] == $past(flags_a.fast_threshold_detect))
    else $error("control bit source wrong");
  chk_bit0_only: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && ctrl_cnt_q == 2'h1 |=> out_a_q.ctrl[2:1] == 2'h0)
    else $error("absent upper control bits driven");
  chk_fmt_twos: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && format_q == 8'h01 && !ch_order_q[0] |=> out_a_q.sample == $past(samp_a))
    else $error("two's complement sample altered");
  chk_swap_b: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && ch_order_q[0] && format_q == 8'h01 |=> out_b_q.sample == $past(samp_a))
    else $error("channel swap wrong on second output");

  // ==========================================================
  // Interrupt and lane checks
  chk_irq_level: assert property (@(posedge core_clk) disable iff (srst)
    clk_en |=> irq_q == (($past(irq_stat_q) & $past(irq_mask_q)) != 8'h00))
    else $error("interrupt level wrong");
  chk_irq_set_wins: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && new_or[0] |=> irq_stat_q[0])
    else $error("new overrange not latched");
  chk_irq_clear: assert property (@(posedge core_clk) disable iff (srst)
    clk_en && wr_stb && idx == IDX_IRQ_STAT && wdat[0] && !new_or[0] |=> !irq_stat_q[0])
    else $error("interrupt status not cleared");
  chk_lane_copy: assert property (@(posedge core_clk) disable iff (srst)
    clk_en |=> lane_rate_low_q == $past(lane_q[4]))
    else $error("lane rate bit not copied");

  cov_or_clear: cover property (@(posedge core_clk) or_flags_q[0] ##1 !or_flags_q[0]);
  cov_swap: cover property (@(posedge core_clk) ch_order_q[0] && clk_en);
  cov_irq: cover property (@(posedge core_clk) irq_q);
  cov_offset_fmt: cover property (@(posedge core_clk) clk_en && format_q == 8'h00);
  cov_ctrl_all: cover property (@(posedge core_clk) clk_en && ctrl_cnt_q == 2'h3);

endmodule // adc_output_format_control

// ### design/ctrl_bit_mux.sv
// Source selection for one appended control bit
module ctrl_bit_mux
  import ofc_pkg::*;
(
  // Selection
  input  wire logic [2:0]    code,
  input  wire logic          present,
  // Sources
  input  wire sample_flags_t flags,
  // Result
  output logic               bit_out
);

  always_comb begin
    unique case (code)
      SRC_TIE_LOW:   bit_out = 1'b0;
      SRC_OVERRANGE: bit_out = flags.overrange;
      SRC_MONITOR:   bit_out = flags.monitor;
      SRC_FAST_DET:  bit_out = flags.fast_threshold_detect;
      SRC_PUNISH1:   bit_out = flags.variable_range_monitor;
      default:       bit_out = 1'b0;
    endcase
    if (!present) begin
      bit_out = 1'b0;
    end
  end

endmodule // ctrl_bit_mux

// ### inc/ofc_pkg.sv
// Package: register map, field layout, reset values and carrier types
package ofc_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [11:0] IDX_SEL_A     = 12'h559;
  localparam logic [11:0] IDX_SEL_B     = 12'h55A;
  localparam logic [11:0] IDX_FORMAT    = 12'h561;
  localparam logic [11:0] IDX_OR_CLEAR  = 12'h562;
  localparam logic [11:0] IDX_OR_FLAGS  = 12'h563;
  localparam logic [11:0] IDX_CH_ORDER  = 12'h564;
  localparam logic [11:0] IDX_LANE_RATE = 12'h56E;
  localparam logic [11:0] IDX_IRQ_STAT  = 12'h570;
  localparam logic [11:0] IDX_IRQ_MASK  = 12'h571;
  localparam logic [11:0] IDX_CTRL_CNT  = 12'h572;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_SEL_A     = 8'h00;
  localparam logic [7:0] RST_SEL_B     = 8'h01;
  localparam logic [7:0] RST_FORMAT    = 8'h01;
  localparam logic [7:0] RST_OR_CLEAR  = 8'h00;
  localparam logic [7:0] RST_CH_ORDER  = 8'h00;
  localparam logic [7:0] RST_LANE_RATE = 8'h10;
  localparam logic [7:0] RST_IRQ_MASK  = 8'h00;
  localparam logic [1:0] RST_CTRL_CNT  = 2'h0;

  // ==========================================================
  // Field positions and writable masks
  localparam int SEL_BIT0_LSB = 0;
  localparam int SEL_BIT1_LSB = 4;
  localparam int SEL_BIT2_LSB = 0;
  localparam int FMT_INVERT   = 2;
  localparam logic [7:0] MASK_SEL_A     = 8'h77;
  localparam logic [7:0] MASK_SEL_B     = 8'h07;
  localparam logic [7:0] MASK_FORMAT    = 8'h07;
  localparam logic [7:0] MASK_CH_ORDER  = 8'h01;
  localparam logic [7:0] MASK_LANE_RATE = 8'h10;

  // ==========================================================
  // Control-bit source codes
  typedef enum logic [2:0] {
    SRC_TIE_LOW   = 3'h0,
    SRC_OVERRANGE = 3'h1,
    SRC_MONITOR   = 3'h2,
    SRC_FAST_DET  = 3'h3,
    SRC_PUNISH1   = 3'h4
  } ctrl_src_t;

  typedef enum logic [1:0] {
    FMT_OFFSET_BIN = 2'h0,
    FMT_TWOS_COMP  = 2'h1
  } num_fmt_t;

  localparam int SAMPLE_W = 14;
  localparam int NUM_VC   = 8;

  // Per-sample status inputs for one channel
  typedef struct packed {
    logic overrange;
    logic monitor;
    logic fast_threshold_detect;
    logic variable_range_monitor;
  } sample_flags_t;

  // One output word: sample and three control bits
  typedef struct packed {
    logic [SAMPLE_W-1:0] sample;
    logic [2:0]          ctrl;
  } out_word_t;

endpackage : ofc_pkg

// ### tb/adc_output_format_control_tb.sv
// Self-checking bench for the output-format register bank
module adc_output_format_control_tb
  import ofc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Signals
  logic                core_clk;
  logic                srst;
  logic                clk_en;
  logic                wb_cyc_i;
  logic                wb_stb_i;
  logic                wb_we_i;
  logic [13:0]         wb_adr_i;
  logic [3:0]          wb_sel_i;
  logic [31:0]         wb_dat_i;
  logic [31:0]         wb_dat_o;
  logic                wb_ack_o;
  logic [SAMPLE_W-1:0] samp_a;
  logic [SAMPLE_W-1:0] samp_b;
  sample_flags_t       flags_a;
  sample_flags_t       flags_b;
  logic [NUM_VC-1:0]   vc_overrange;
  out_word_t           out_a_q;
  out_word_t           out_b_q;
  logic                lane_rate_low_q;
  logic                irq_q;
  int                  error_cnt;
  int                  num_checks;
  logic                exp_ctl;
  logic [11:0]         r_idx [0:9];
  logic [7:0]          r_rst [0:9];

  adc_output_format_control DUT (
    .core_clk(core_clk), .srst(srst), .clk_en(clk_en),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .samp_a(samp_a), .samp_b(samp_b), .flags_a(flags_a), .flags_b(flags_b),
    .vc_overrange(vc_overrange), .out_a_q(out_a_q), .out_b_q(out_b_q),
    .lane_rate_low_q(lane_rate_low_q), .irq_q(irq_q)
  );

  always #50 core_clk = ~core_clk;

  // ==========================================================
  // Verdict and compares
  task automatic report_and_stop;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_out(input out_word_t got, input out_word_t exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t output word %h expected %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // Wishbone classic single cycle
  task automatic xfer(input logic [11:0] idx, input logic we, input logic [7:0] wd,
                      output logic [31:0] rd);
    int n;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h0, wd};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      $display("MISMATCH %0t no acknowledge", $time);
      report_and_stop;
    end
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] unused;
    xfer(idx, 1'b1, d, unused);
  endtask

  task automatic rchk(input logic [11:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    xfer(idx, 1'b0, 8'h00, d);
    chk_reg(d, {24'h0, exp});
  endtask

  // Drive one sample pair, land it in the output register
  task automatic put(input logic [13:0] a, input logic [13:0] b, input logic [3:0] f);
    @(posedge core_clk);
    samp_a  <= a;
    samp_b  <= b;
    flags_a <= sample_flags_t'(f);
    flags_b <= 4'h0;
    @(posedge core_clk);
    #1;
  endtask

  task automatic pulse_or(input logic [7:0] v);
    @(posedge core_clk);
    vc_overrange <= v;
    @(posedge core_clk);
    vc_overrange <= 8'h00;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  function automatic logic pick(input logic [2:0] c, input sample_flags_t f);
    case (c)
      SRC_OVERRANGE: return f.overrange;
      SRC_MONITOR:   return f.monitor;
      SRC_FAST_DET:  return f.fast_threshold_detect;
      SRC_PUNISH1:   return f.variable_range_monitor;
      default:       return 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    core_clk = 1'b0; srst = 1'b1; clk_en = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0;
    wb_we_i = 1'b0; wb_adr_i = 14'h0; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
    samp_a = 14'h0; samp_b = 14'h0; flags_a = 4'h0; flags_b = 4'h0; vc_overrange = 8'h00;
    error_cnt = 0; num_checks = 0;
    r_idx = '{12'h559, 12'h55A, 12'h561, 12'h562, 12'h563, 12'h564, 12'h56E, 12'h571,
              12'h572, 12'h560};
    r_rst = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00};
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk_bit(lane_rate_low_q, 1'b1);
    chk_bit(irq_q, 1'b0);
    for (int i = 0; i < 10; i++) rchk(r_idx[i], r_rst[i]);
    // Writable bits only, read-only ignores writes
    wr(12'h559, 8'hFF);
    rchk(12'h559, 8'h77);
    wr(12'h55A, 8'hFF);
    rchk(12'h55A, 8'h07);
    wr(12'h563, 8'hFF);
    rchk(12'h563, 8'h00);
    wr(12'h56E, 8'h00);
    rchk(12'h56E, 8'h00);
    chk_bit(lane_rate_low_q, 1'b0);
    wr(12'h560, 8'hFF);
    rchk(12'h560, 8'h00);
    // Sample format, invert and swap
    put(14'h1234, 14'h0ABC, 4'h0);
    chk_out(out_a_q, {14'h1234, 3'h0});
    wr(12'h561, 8'h00);
    put(14'h1234, 14'h0ABC, 4'h0);
    chk_out(out_a_q, {14'h3234, 3'h0});
    wr(12'h561, 8'h05);
    put(14'h1234, 14'h0ABC, 4'h0);
    chk_out(out_a_q, {14'h2DCB, 3'h0});
    wr(12'h561, 8'h01);
    wr(12'h564, 8'h01);
    put(14'h1234, 14'h0ABC, 4'h0);
    chk_out(out_a_q, {14'h0ABC, 3'h0});
    chk_out(out_b_q, {14'h1234, 3'h0});
    wr(12'h564, 8'h00);
    // Clock enable low freezes the output stage
    @(posedge core_clk);
    clk_en <= 1'b0;
    put(14'h2222, 14'h0ABC, 4'h0);
    chk_out(out_a_q, {14'h1234, 3'h0});
    @(posedge core_clk);
    clk_en <= 1'b1;
    @(posedge core_clk);
    #1;
    chk_out(out_a_q, {14'h2222, 3'h0});
    // Every selector code on all three control bits
    wr(12'h572, 8'h03);
    for (int c = 0; c < 8; c++) begin
      wr(12'h559, {1'b0, 3'(c), 1'b0, 3'(c)});
      wr(12'h55A, {5'h0, 3'(c)});
      for (int p = 0; p < 2; p++) begin
        put(14'h0100, 14'h0, p ? 4'h5 : 4'hA);
        exp_ctl = pick(3'(c), sample_flags_t'(p ? 4'h5 : 4'hA));
        chk_out(out_a_q, {14'h0100, {3{exp_ctl}}});
      end
    end
    wr(12'h559, 8'h11);
    wr(12'h572, 8'h01);
    put(14'h0100, 14'h0, 4'h8);
    chk_out(out_a_q, {14'h0100, 3'h1});
    // Sticky overrange flags and their clear bits
    pulse_or(8'h05);
    rchk(12'h563, 8'h05);
    repeat (5) @(posedge core_clk);
    rchk(12'h563, 8'h05);
    rchk(12'h570, 8'h05);
    wr(12'h571, 8'h00);
    repeat (3) @(posedge core_clk);
    #1;
    chk_bit(irq_q, 1'b0);
    wr(12'h571, 8'hFF);
    repeat (3) @(posedge core_clk);
    #1;
    chk_bit(irq_q, 1'b1);
    wr(12'h562, 8'h01);
    rchk(12'h563, 8'h04);
    pulse_or(8'h01);
    rchk(12'h563, 8'h04);
    wr(12'h562, 8'h00);
    pulse_or(8'h01);
    rchk(12'h563, 8'h05);
    wr(12'h570, 8'hFF);
    rchk(12'h570, 8'h00);
    repeat (3) @(posedge core_clk);
    #1;
    chk_bit(irq_q, 1'b0);
    // Reset in mid-run restores registers and outputs
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    #1;
    chk_out(out_a_q, 17'h0);
    chk_bit(lane_rate_low_q, 1'b1);
    chk_bit(irq_q, 1'b0);
    rchk(12'h563, 8'h00);
    rchk(12'h562, 8'h00);
    rchk(12'h56E, 8'h10);
    report_and_stop;
  end

endmodule // adc_output_format_control_tb
